// >>> trap_pkg.sv
// Purpose: constants for the trap and interrupt priority block
// Assumes: classic wishbone slave, 32-bit data, word aligned registers
// Notes:   offsets and vectors are design choices
package trap_pkg;
    // =====================================================
    // register map
    localparam logic [7:0]  OFF_IRQ_EN0      = 8'h00;
    localparam logic [7:0]  OFF_IRQ_PRI2     = 8'h04;
    localparam logic [7:0]  OFF_STACK_LIMIT  = 8'h08;
    localparam logic [7:0]  OFF_RESET_CTRL   = 8'h0c;
    localparam logic [7:0]  OFF_TRAP_STATUS  = 8'h10;
    localparam logic [7:0]  OFF_TRAP_ACK     = 8'h14;
    // =====================================================
    // reset values and masks
    localparam logic [15:0] RST_IRQ_EN0      = 16'h0000;
    localparam logic [15:0] RST_IRQ_PRI2     = 16'h4444;
    localparam logic [15:0] PRI2_MASK        = 16'h7777;
    localparam logic [15:0] RST_STACK_LIMIT  = 16'hffff;
    localparam logic [15:0] STACK_FLOOR      = 16'h0800;
    // =====================================================
    // field positions
    localparam int          IRQ_EN_EXT0_BIT  = 0;
    localparam int          IRQ_EN_CAP1_BIT  = 1;
    localparam int          IRQ_EN_CMP1_BIT  = 2;
    localparam int          PRI_SPI_LSB      = 0;
    localparam int          PRI_URX_LSB      = 4;
    localparam int          PRI_UTX_LSB      = 8;
    localparam int          PRI_ADC_LSB      = 12;
    localparam int          TRAP_CONFLICT_BIT = 15;
    // =====================================================
    // trap levels, hard 12..15, soft 8..11
    localparam logic [3:0]  LVL_ARITH        = 4'hb;
    localparam logic [3:0]  LVL_ADDR         = 4'hc;
    localparam logic [3:0]  LVL_STACK        = 4'hd;
    localparam logic [3:0]  LVL_OSC          = 4'he;
    localparam logic [3:0]  LVL_HARD_MIN     = 4'hc;
    localparam logic [3:0]  LVL_SOFT_MIN     = 4'h8;
    localparam logic [23:0] VEC_BASE         = 24'h000004;
endpackage

// >>> trap_irq_unit.sv
// Purpose: trap detection, hard trap conflict reset, irq enable/priority regs
// Assumes: core gives per-cycle access qualifiers; oscillator fail is async
// Notes:   single clock, synchronous active low reset
//
// Design decisions made here: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ns

// Summary of operation
// - odd address word access raises address trap
// - read of unimplemented data raises address trap
// - data access to missing program memory traps
// - fetch from vector space raises address trap
// - mac split spaces treat other space unimplemented
// - literal branch to missing program memory traps
// - executing from missing program memory traps
// - stack pointer above limit raises stack trap
// - stack pointer below 0x0800 raises stack trap
// - oscillator fallback to rc raises osc trap
// - simultaneous traps served by fixed priority
// - levels 8 to 11 are soft traps
// - levels 12 to 15 hard: addr, stack, osc
// - hard trap stalls code until acknowledged
// - lower hard trap under higher one conflicts
// - conflict resets device, sets flag bit 15
// - enable bits compare1, capture1, external0
// - priority field value is priority, 0 disables
// - priority register 2 field layout
// - unused priority bits read zero, ignore writes
module trap_irq_unit
    import trap_pkg::*;
#(
    parameter logic [23:0] VEC_STRIDE = 24'h000002,
    parameter logic [23:0] VEC_BASE_P = VEC_BASE
) (
    // clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        nrst_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // data access from address generators
    input  wire logic        dacc_valid_i,
    input  wire logic        dacc_word_i,
    input  wire logic        dacc_read_i,
    input  wire logic        dacc_mac_i,
    input  wire logic        dacc_yspace_i,
    input  wire logic        dacc_in_x_i,
    input  wire logic        dacc_in_y_i,
    input  wire logic        dacc_data_impl_i,
    input  wire logic        dacc_prog_i,
    input  wire logic [15:0] dacc_addr_i,
    // program flow from core
    input  wire logic        fetch_valid_i,
    input  wire logic        fetch_vector_i,
    input  wire logic        fetch_impl_i,
    input  wire logic        branch_lit_i,
    input  wire logic        branch_impl_i,
    input  wire logic        prog_impl_i,
    // stack pointer and other traps
    input  wire logic        sp_load_i,
    input  wire logic [15:0] sp_value_i,
    input  wire logic        arith_trap_i,
    input  wire logic        osc_fail_i,
    input  wire logic        trap_ack_i,
    // outputs to core
    output logic             trap_req_o,
    output logic      [3:0]  trap_level_o,
    output logic      [23:0] trap_vector_o,
    output logic             hard_stall_o,
    output logic             conflict_reset_o,
    // interrupt settings to controller
    output logic      [2:0]  irq_en_o,
    output logic      [2:0]  adc_pri_o,
    output logic      [2:0]  utx_pri_o,
    output logic      [2:0]  urx_pri_o,
    output logic      [2:0]  spi_pri_o
);
    // =====================================================
    // state
    typedef struct packed {
        logic [15:0] irq_en0;
        logic [15:0] irq_pri2;
        logic [15:0] stack_limit;
        logic        conflict_flag;
        logic [3:0]  pending;      // bit0 arith, 1 addr, 2 stack, 3 osc
        logic [3:0]  active_lvl;   // 0 when none in service
        logic        in_service;
        logic        conflict_rst;
        logic        osc_s1;
        logic        osc_s2;
        logic        osc_prev;
        logic        ack;
        logic [31:0] rdata;
    } state_t;

    state_t st_ff;
    state_t nxt_st;

    // =====================================================
    // trap detection
    logic       addr_err;
    logic       stack_err;
    logic       osc_err;
    logic       mac_bad;
    logic [3:0] new_traps;
    logic [3:0] all_pend;
    logic [3:0] top_lvl;
    logic [3:0] new_hard_lvl;
    logic [3:0] held_hard_lvl;
    logic       has_hard_new;
    logic       conflict;
    logic       wb_hit;
    logic [15:0] wr16;

    always_comb begin
        mac_bad   = dacc_mac_i & (dacc_yspace_i ? dacc_in_x_i : dacc_in_y_i);
        addr_err  = 1'b0;
        if (dacc_valid_i && dacc_word_i && dacc_addr_i[0]) begin
            addr_err = 1'b1;
        end
        if (dacc_valid_i && dacc_read_i && !dacc_prog_i && (!dacc_data_impl_i || mac_bad)) begin
            addr_err = 1'b1;
        end
        if (dacc_valid_i && dacc_prog_i && !prog_impl_i) begin
            addr_err = 1'b1;
        end
        if (fetch_valid_i && fetch_vector_i) begin
            addr_err = 1'b1;
        end
        if (branch_lit_i && !branch_impl_i) begin
            addr_err = 1'b1;
        end
        if (fetch_valid_i && !fetch_impl_i) begin
            addr_err = 1'b1;
        end
        stack_err = sp_load_i & ((sp_value_i > st_ff.stack_limit)
                               | (sp_value_i < STACK_FLOOR));
        osc_err   = st_ff.osc_s2 & ~st_ff.osc_prev;
        new_traps = {osc_err, stack_err, addr_err, arith_trap_i};
        all_pend  = st_ff.pending | new_traps;
        // fixed priority, highest level wins
        if (all_pend[3]) begin
            top_lvl = LVL_OSC;
        end else if (all_pend[2]) begin
            top_lvl = LVL_STACK;
        end else if (all_pend[1]) begin
            top_lvl = LVL_ADDR;
        end else if (all_pend[0]) begin
            top_lvl = LVL_ARITH;
        end else begin
            top_lvl = 4'h0;
        end
        // lowest new hard trap against highest held hard trap
        has_hard_new = |new_traps[3:1];
        if (new_traps[1]) begin
            new_hard_lvl = LVL_ADDR;
        end else if (new_traps[2]) begin
            new_hard_lvl = LVL_STACK;
        end else if (new_traps[3]) begin
            new_hard_lvl = LVL_OSC;
        end else begin
            new_hard_lvl = 4'h0;
        end
        // highest hard level already held, in service or pending
        held_hard_lvl = 4'h0;
        if (st_ff.in_service && st_ff.active_lvl >= LVL_HARD_MIN) begin
            held_hard_lvl = st_ff.active_lvl;
        end
        if (st_ff.pending[3] && LVL_OSC > held_hard_lvl) begin
            held_hard_lvl = LVL_OSC;
        end
        if (st_ff.pending[2] && LVL_STACK > held_hard_lvl) begin
            held_hard_lvl = LVL_STACK;
        end
        if (st_ff.pending[1] && LVL_ADDR > held_hard_lvl) begin
            held_hard_lvl = LVL_ADDR;
        end
        conflict = has_hard_new && (new_hard_lvl < held_hard_lvl);
    end

    assign wb_hit = wb_cyc_i & wb_stb_i & ~st_ff.ack;
    assign wr16   = {wb_sel_i[1] ? wb_dat_i[15:8] : 8'h00, wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00};

    // =====================================================
    // next state
    always_comb begin
        nxt_st          = st_ff;
        nxt_st.osc_s1   = osc_fail_i;
        nxt_st.osc_s2   = st_ff.osc_s1;
        nxt_st.osc_prev = st_ff.osc_s2;
        nxt_st.ack      = wb_hit;
        nxt_st.conflict_rst = 1'b0;
        nxt_st.pending  = all_pend;
        // trap taken into service when none is held
        if (!st_ff.in_service && top_lvl != 4'h0) begin
            nxt_st.in_service = 1'b1;
            nxt_st.active_lvl = top_lvl;
        end
        if (st_ff.in_service && trap_ack_i) begin
            nxt_st.in_service = 1'b0;
            nxt_st.active_lvl = 4'h0;
            case (st_ff.active_lvl)
                LVL_OSC:   nxt_st.pending[3] = new_traps[3];
                LVL_STACK: nxt_st.pending[2] = new_traps[2];
                LVL_ADDR:  nxt_st.pending[1] = new_traps[1];
                LVL_ARITH: nxt_st.pending[0] = new_traps[0];
                default:   nxt_st.pending    = all_pend;
            endcase
        end
        // register access
        nxt_st.rdata = 32'h0000_0000;
        if (wb_hit && wb_we_i) begin
            if (wb_adr_i == OFF_IRQ_EN0) begin
                nxt_st.irq_en0 = wr16;
            end else if (wb_adr_i == OFF_IRQ_PRI2) begin
                nxt_st.irq_pri2 = wr16 & PRI2_MASK;
            end else if (wb_adr_i == OFF_STACK_LIMIT) begin
                nxt_st.stack_limit = wr16;
            end else if (wb_adr_i == OFF_RESET_CTRL) begin
                if (wb_sel_i[1] && !wb_dat_i[TRAP_CONFLICT_BIT]) begin
                    nxt_st.conflict_flag = 1'b0;
                end
            end
        end else if (wb_hit) begin
            if (wb_adr_i == OFF_IRQ_EN0) begin
                nxt_st.rdata = {16'h0000, st_ff.irq_en0};
            end else if (wb_adr_i == OFF_IRQ_PRI2) begin
                nxt_st.rdata = {16'h0000, st_ff.irq_pri2 & PRI2_MASK};
            end else if (wb_adr_i == OFF_STACK_LIMIT) begin
                nxt_st.rdata = {16'h0000, st_ff.stack_limit};
            end else if (wb_adr_i == OFF_RESET_CTRL) begin
                nxt_st.rdata = {16'h0000, st_ff.conflict_flag, 15'h0000};
            end else if (wb_adr_i == OFF_TRAP_STATUS) begin
                nxt_st.rdata = {16'h0000, 3'h0, st_ff.in_service, st_ff.active_lvl, 4'h0, st_ff.pending};
            end
        end
        // conflict: reset registers and trap state (bus ack, read data and osc sync keep running), set the flag
        if (conflict) begin
            nxt_st.irq_en0       = RST_IRQ_EN0;
            nxt_st.irq_pri2      = RST_IRQ_PRI2;
            nxt_st.stack_limit   = RST_STACK_LIMIT;
            nxt_st.pending       = 4'h0;
            nxt_st.in_service    = 1'b0;
            nxt_st.active_lvl    = 4'h0;
            nxt_st.conflict_flag = 1'b1;
            nxt_st.conflict_rst  = 1'b1;
        end
    end

    // =====================================================
    // registers
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            st_ff             <= '0;
            st_ff.irq_en0     <= RST_IRQ_EN0;
            st_ff.irq_pri2    <= RST_IRQ_PRI2;
            st_ff.stack_limit <= RST_STACK_LIMIT;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // =====================================================
    // outputs
    assign wb_ack_o         = st_ff.ack;
    assign wb_dat_o         = st_ff.rdata;
    assign trap_req_o       = st_ff.in_service;
    assign trap_level_o     = st_ff.active_lvl;
    assign trap_vector_o    = VEC_BASE_P + VEC_STRIDE * {20'h00000, st_ff.active_lvl - LVL_SOFT_MIN};
    assign hard_stall_o     = st_ff.in_service && st_ff.active_lvl >= LVL_HARD_MIN;
    assign conflict_reset_o = st_ff.conflict_rst;
    assign irq_en_o         = st_ff.irq_en0[2:0];
    assign adc_pri_o        = st_ff.irq_pri2[PRI_ADC_LSB +: 3];
    assign utx_pri_o        = st_ff.irq_pri2[PRI_UTX_LSB +: 3];
    assign urx_pri_o        = st_ff.irq_pri2[PRI_URX_LSB +: 3];
    assign spi_pri_o        = st_ff.irq_pri2[PRI_SPI_LSB +: 3];
endmodule

// >>> trap_irq_unit_properties.sv
// Purpose: port assertions for trap_irq_unit
// Assumes: master holds address until ack
// Notes:   bound to every trap_irq_unit
`timescale 1ns/1ns
module trap_irq_unit_checker
    import trap_pkg::*;
#(
    parameter logic [23:0] VEC_STRIDE = 24'h000002,
    parameter logic [23:0] VEC_BASE_P = VEC_BASE
) (
    // bus and clock
    input wire logic        ref_clk_i, nrst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    // trap side
    input wire logic        dacc_valid_i, dacc_word_i, sp_load_i, osc_fail_i, trap_ack_i,
    input wire logic [15:0] dacc_addr_i, sp_value_i,
    input wire logic        trap_req_o, hard_stall_o, conflict_reset_o,
    input wire logic [3:0]  trap_level_o,
    input wire logic [23:0] trap_vector_o,
    input wire logic [2:0]  adc_pri_o, utx_pri_o, urx_pri_o, spi_pri_o
);
    // ====
    // checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_ack_next_edge: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
    a_trap_held: assert property (trap_req_o && !trap_ack_i |=> trap_req_o || conflict_reset_o)
        else $error("trap dropped");
    a_stall_hard: assert property (hard_stall_o == (trap_req_o && trap_level_o >= LVL_HARD_MIN))
        else $error("stall wrong");
    a_vector_map: assert property (trap_req_o |->
        trap_vector_o == VEC_BASE_P + VEC_STRIDE * (24'(trap_level_o) - 24'h8)) else $error("vector wrong");
    a_misalign_trap: assert property (dacc_valid_i && dacc_word_i && dacc_addr_i[0] && !trap_req_o
        |-> ##[1:2] (trap_req_o && trap_level_o >= LVL_ADDR)) else $error("no address trap");
    a_underflow_trap: assert property (sp_load_i && sp_value_i < STACK_FLOOR && !trap_req_o
        |-> ##[1:2] (trap_req_o && trap_level_o >= LVL_STACK)) else $error("no stack trap");
    a_osc_trap: assert property ($rose(osc_fail_i) && !trap_req_o
        |-> ##[1:8] (trap_req_o && trap_level_o == LVL_OSC)) else $error("no osc trap");
    a_pri_read: assert property (wb_ack_o && !wb_we_i && wb_adr_i == OFF_IRQ_PRI2 |->
        wb_dat_o == {17'h0, adc_pri_o, 1'h0, utx_pri_o, 1'h0, urx_pri_o, 1'h0, spi_pri_o}) else $error("pri read");
    a_conflict_pulse: assert property (conflict_reset_o |=> !conflict_reset_o && !trap_req_o)
        else $error("conflict state kept");
    c_conflict: cover property (conflict_reset_o);
    c_arith: cover property (trap_req_o && trap_level_o == LVL_ARITH);
    c_pri_read: cover property (wb_ack_o && !wb_we_i && wb_adr_i == OFF_IRQ_PRI2);
endmodule
bind trap_irq_unit trap_irq_unit_checker #(.VEC_STRIDE(VEC_STRIDE), .VEC_BASE_P(VEC_BASE_P)) checker_inst (.*);

// >>> trap_core_model.sv
// Purpose: core model that acknowledges traps
// Assumes: ack is sampled on the rising edge
// Notes:   dly_i sets service time
`timescale 1ns/1ns
module trap_core_model (
    // clock and handshake
    input  wire logic       ref_clk_i,
    input  wire logic       trap_req_i,
    input  wire logic [7:0] dly_i,
    output logic            trap_ack_o = 1'h0
);
    // ====
    // service timer
    logic [7:0] cnt_ff = 8'h00;
    always @(posedge ref_clk_i) begin
        trap_ack_o <= 1'h0;
        cnt_ff <= (trap_req_i && !trap_ack_o && cnt_ff < dly_i) ? cnt_ff + 8'h01 : 8'h00;
        if (trap_req_i && !trap_ack_o && cnt_ff >= dly_i) trap_ack_o <= 1'h1;
    end
endmodule

// >>> trap_irq_unit_tb.sv
// Purpose: self-checking bench for trap_irq_unit
// Assumes: core model acks each trap dly+1 cycles after its request
// Notes:   drivers queue expectations for the monitor, main sequence checks the rest
`timescale 1ns/1ns
module trap_irq_unit_tb;
    import trap_pkg::*;
    // ====
    // signals
    logic        ref_clk_i = 1'h0, nrst_i = 1'h0, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
    logic        dacc_valid_i, dacc_word_i, dacc_read_i, dacc_mac_i, dacc_yspace_i, dacc_in_x_i, dacc_in_y_i;
    logic        dacc_data_impl_i, dacc_prog_i, prog_impl_i, fetch_valid_i, fetch_vector_i, fetch_impl_i;
    logic        branch_lit_i, branch_impl_i, arith_trap_i, sp_load_i = 1'h0, osc_fail_i = 1'h0, trap_ack_i;
    logic        wb_ack_o, trap_req_o, hard_stall_o, conflict_reset_o, req_q = 1'h0, ack_q = 1'h0;
    logic [3:0]  wb_sel_i = 4'h3, trap_level_o, lv_q[$];
    logic [7:0]  wb_adr_i = 8'h00, dly = 8'h03;
    logic [15:0] dacc_addr_i = 16'h0000, sp_value_i = 16'h1000, pat = 16'h054a, v;
    logic [15:0] tp[9] = '{16'hc54a, 16'ha44a, 16'h858a, 16'h057a, 16'hbd4a, 16'h054c, 16'h0562, 16'h054b, 16'hc54b};
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd_q[$];
    logic [23:0] trap_vector_o;
    logic [2:0]  irq_en_o, adc_pri_o, utx_pri_o, urx_pri_o, spi_pri_o;
    int          err_count = 0, checked = 0, cyc_n = 0, conf_n = 0;
    assign {dacc_valid_i, dacc_word_i, dacc_read_i, dacc_mac_i, dacc_yspace_i, dacc_in_x_i, dacc_in_y_i,
            dacc_data_impl_i, dacc_prog_i, prog_impl_i, fetch_valid_i, fetch_vector_i, fetch_impl_i,
            branch_lit_i, branch_impl_i, arith_trap_i} = pat;
    always #10 ref_clk_i = ~ref_clk_i;
    trap_irq_unit trap_irq_unit_inst (.*);
    trap_core_model trap_core_model_inst (.ref_clk_i(ref_clk_i), .trap_req_i(trap_req_o), .dly_i(dly),
                                          .trap_ack_o(trap_ack_i));
    // ====
    // tasks
    task automatic chk(input string nm, input logic [31:0] e, s);
        checked++;
        if (s !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic bus(input logic we, input logic [7:0] a, input logic [15:0] d, input logic [31:0] me);
        @(posedge ref_clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, a, 16'h0000, d};
        if (!we) rd_q.push_back(me);
        do @(posedge ref_clk_i); while (wb_ack_o !== 1'h1);
        {wb_cyc_i, wb_stb_i} <= 2'h0;
    endtask
    task automatic trap(input logic [15:0] p, a, input logic [17:0] s, input logic [3:0] l0, l1);
        @(posedge ref_clk_i);
        {pat, dacc_addr_i, osc_fail_i, sp_load_i, sp_value_i} <= {p, a, s};
        if (l0 != 4'h0) lv_q.push_back(l0);
        if (l1 != 4'h0) lv_q.push_back(l1);
        @(posedge ref_clk_i);
        {pat, sp_load_i} <= {16'h054a, 1'h0};
        for (int i = 0; i < 300 && (lv_q.size() > 0 || trap_req_o); i++) @(posedge ref_clk_i);
        repeat (4) @(posedge ref_clk_i);
    endtask
    // ====
    // monitor
    always @(posedge ref_clk_i) begin
        cyc_n++;
        if (cyc_n > 20000) begin
            err_count++;
            summarize();
        end
        if (conflict_reset_o === 1'h1) conf_n++;
        if (wb_ack_o === 1'h1 && wb_we_i === 1'h0) begin
            chk("read data", {16'h0, rd_q[0][15:0]}, wb_dat_o & {16'hffff, rd_q[0][31:16]});
            rd_q.delete(0);
        end
        if (trap_req_o === 1'h1 && (!req_q || ack_q))
            chk("trap level", {28'h0, (lv_q.size() > 0) ? lv_q.pop_front() : 4'h0}, {28'h0, trap_level_o});
        {req_q, ack_q} = {trap_req_o, trap_ack_i};
    end
    // ====
    // main sequence
    initial begin
        void'($urandom(66575));
        repeat (8) @(posedge ref_clk_i);
        nrst_i <= 1'h1;
        bus(1'h0, OFF_IRQ_EN0, 16'h0000, {16'hffff, RST_IRQ_EN0});
        bus(1'h0, OFF_IRQ_PRI2, 16'h0000, {16'hffff, RST_IRQ_PRI2});
        bus(1'h0, OFF_STACK_LIMIT, 16'h0000, {16'hffff, RST_STACK_LIMIT});
        bus(1'h0, 8'h40, 16'h0000, 32'hffff0000);
        for (int i = 0; i < 3; i++) begin
            bus(1'h1, OFF_IRQ_EN0, 16'h0001 << i, 32'h0);
            chk("irq enable", 32'h1 << i, {29'h0, irq_en_o});
        end
        repeat (4) begin
            v = 16'($urandom);
            bus(1'h1, OFF_IRQ_PRI2, v, 32'h0);
            bus(1'h0, OFF_IRQ_PRI2, 16'h0000, {16'hffff, v & PRI2_MASK});
            chk("priorities", {16'h0, v & PRI2_MASK},
                {17'h0, adc_pri_o, 1'h0, utx_pri_o, 1'h0, urx_pri_o, 1'h0, spi_pri_o});
        end
        $display("register test done");
        bus(1'h1, OFF_STACK_LIMIT, 16'h1000, 32'h0);
        bus(1'h0, OFF_STACK_LIMIT, 16'h0000, 32'hffff1000);
        for (int i = 0; i < 9; i++) begin
            v = 16'($urandom) & 16'hfffe;
            trap(tp[i], v | 16'(i == 0 || i == 8), 18'h01000,
                 LVL_ADDR - 4'(i == 7), (i == 8) ? LVL_ARITH : 4'h0);
        end
        trap(16'h054a, 16'h0000, 18'h11002, LVL_STACK, 4'h0);
        trap(16'h054a, 16'h0000, 18'h11000, 4'h0, 4'h0);
        trap(16'h054a, 16'h0000, 18'h107fe, LVL_STACK, 4'h0);
        trap(16'h054a, 16'h0000, 18'h10800, 4'h0, 4'h0);
        trap(16'h054a, 16'h0000, 18'h21000, LVL_OSC, 4'h0);
        $display("trap source test done");
        @(posedge ref_clk_i);
        {dly, sp_load_i, sp_value_i} <= {8'h14, 1'h1, 16'h07fe};
        lv_q.push_back(LVL_STACK);
        @(posedge ref_clk_i);
        sp_load_i <= 1'h0;
        repeat (3) @(posedge ref_clk_i);
        trap(16'hc54a, 16'h0011, 18'h21000, 4'h0, 4'h0);
        chk("conflict pulses", 32'h1, conf_n);
        bus(1'h0, OFF_RESET_CTRL, 16'h0000, 32'h80008000);
        bus(1'h1, OFF_RESET_CTRL, 16'h0000, 32'h0);
        bus(1'h0, OFF_RESET_CTRL, 16'h0000, 32'h80000000);
        $display("conflict test done");
        summarize();
    end
endmodule
